// File: bench/single_wire_uart_trigger_response_tb.sv
`timescale 1ns/1ps
// both ends joined on one line; bench plays the user of each side
module single_wire_uart_trigger_response_tb;
  import swu_pkg::*;
  logic clock; // 25 MHz system clock
  logic reset_n; // synchronous reset, active low
  logic host_start; // host trigger request
  logic [12:0] bit_cycles; // host bit period in cycles
  logic [2:0] interface_select_setting; // link select code
  logic [7:0] byte_gap_setting; // gap between reply bytes
  logic acq_done; // acquisition finished
  logic [15:0] acq_data; // acquisition result
  logic acq_start; // device asks for an acquisition
  logic awake; // device out of idle
  logic [12:0] bit_period; // last measured bit period
  logic host_busy; // host transaction running
  logic [15:0] result; // received result
  logic result_valid; // result pulse
  logic frame_error; // host receive fault pulse
  logic dev_oe_seen; // device pull-down, for waiting on it
  logic line; // resolved line level
  logic ce; // clock enable shared by both ends
  int err_count;
  int checked;

  swu_link_if swu_link_if_inst();
  assign dev_oe_seen = swu_link_if_inst.dev_oe;
  assign line = swu_link_if_inst.shared_serial_line;

  // small abort limit keeps stuck low levels from stretching the run
  swu_dev #(.LEVEL_MAX_CYC(17'h007D0)) swu_dev_inst (.clock(clock), .reset_n(reset_n), .ce(ce),
    .link(swu_link_if_inst), .interface_select_setting(interface_select_setting),
    .byte_gap_setting(byte_gap_setting), .acq_start(acq_start), .acq_done(acq_done),
    .acq_data(acq_data), .awake(awake), .bit_period(bit_period));
  // short hunt limit so the silent-device case ends quickly
  swu_host #(.ACQ_MAX_CYC(24'h002EE0)) swu_host_inst (.clock(clock), .reset_n(reset_n), .ce(ce),
    .link(swu_link_if_inst), .start(host_start), .bit_cycles(bit_cycles), .busy(host_busy),
    .result(result), .result_valid(result_valid), .frame_error(frame_error));
  swu_link_checker swu_link_checker_inst (.clock(clock), .reset_n(reset_n),
    .dev_out(swu_link_if_inst.dev_out), .dev_oe(swu_link_if_inst.dev_oe),
    .host_out(swu_link_if_inst.host_out), .host_oe(swu_link_if_inst.host_oe),
    .shared_serial_line(swu_link_if_inst.shared_serial_line));

  // free running clock
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // verdict and end of run
  task automatic close_out;
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one comparison, counted
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // bounded wait for a level; running out ends the run
  task automatic wait_high(ref logic sig, input string what, input int lim);
    int n;
    n = 0;
    while (sig !== 1'b1)
    begin
      @(negedge clock);
      n++;
      if (n > lim)
      begin
        err_count++;
        $display("[FAIL] %s expected 1 seen timeout", what);
        close_out();
      end
    end
  endtask

  // reset held twelve cycles; inputs move on falling edges only
  task automatic do_reset;
    reset_n = 1'b0;
    repeat (12) @(negedge clock);
    reset_n = 1'b1;
  endtask

  // one host request with the given bit period
  task automatic trigger(input logic [12:0] cycles);
    @(negedge clock);
    bit_cycles = cycles;
    host_start = 1'b1;
    @(negedge clock);
    host_start = 1'b0;
  endtask

  // full request and reply at the fastest rate with a non-default byte gap
  task automatic full_reply;
    int hi;
    int longest;
    int n;
    int gap;
    logic fe;
    interface_select_setting = SEL_SINGLE_WIRE;
    byte_gap_setting = 8'h28;
    acq_data = 16'h35C6; // high byte ends in two zeros, so its stop run is stop plus gap
    gap = ((10 + 4 * 40) * 250) / 12; // tenths of us times 25 cycles over 12
    trigger(13'hA2D);
    repeat (4) @(negedge clock);
    check("awake", 1'b1, awake);
    wait_high(acq_start, "acq_start", 9000);
    check("line at acquire", 1'b1, line);
    check("bit_period", 32'hA2D, bit_period);
    repeat (50) @(negedge clock);
    check("dev_oe before done", 1'b0, dev_oe_seen);
    acq_done = 1'b1;
    @(negedge clock);
    acq_done = 1'b0;
    wait_high(dev_oe_seen, "start bit", 20);
    n = 0;
    while (dev_oe_seen === 1'b1 && n < 9000)
    begin
      @(negedge clock);
      n++;
    end
    check("start bit cycles", 32'hA2D, n);
    if (n >= 9000)
      close_out();
    hi = 0;
    longest = 0;
    n = 0;
    fe = 1'b0;
    // the longest high run before the low byte ends is stop bit plus gap
    while (result_valid !== 1'b1 && n < 60000)
    begin
      @(negedge clock);
      n++;
      if (frame_error === 1'b1)
        fe = 1'b1;
      if (line === 1'b1)
        hi++;
      else
      begin
        if (hi > longest)
          longest = hi;
        hi = 0;
      end
    end
    check("result_valid", 1'b1, result_valid);
    if (result_valid !== 1'b1)
      close_out();
    check("result", 16'h35C6, result);
    check("frame_error", 1'b0, fe);
    check("byte gap in range", 1'b1, longest >= 2605 + gap && longest <= 2609 + gap);
    n = 0;
    while (awake === 1'b1 && n < 6000)
    begin
      @(negedge clock);
      n++;
    end
    check("awake after reply", 1'b0, awake);
    if (awake === 1'b1)
      close_out();
    check("line after reply", 1'b1, line);
    check("host busy after reply", 1'b0, host_busy);
  endtask

  // second request at the slowest rate gives a new period
  task automatic remeasure;
    trigger(13'h1458);
    // both ends frozen inside the high pulse: the measured width must not grow
    repeat (2000) @(negedge clock);
    ce = 1'b0;
    repeat (100) @(negedge clock);
    ce = 1'b1;
    wait_high(acq_start, "acq_start slow", 9000);
    check("bit_period slow", 32'h1458, bit_period);
    do_reset();
  endtask

  // pulse one cycle too short for 9600 baud is dropped
  task automatic short_pulse;
    logic seen;
    seen = 1'b0;
    trigger(13'hA2C);
    repeat (6000)
    begin
      @(negedge clock);
      if (acq_start === 1'b1)
        seen = 1'b1;
    end
    check("acq_start on short pulse", 1'b0, seen);
    check("awake on short pulse", 1'b0, awake);
    do_reset();
  endtask

  // other interface select: device stays asleep, host gives up
  task automatic select_off;
    int n;
    logic woke;
    logic fe;
    woke = 1'b0;
    fe = 1'b0;
    interface_select_setting = SEL_DEFAULT;
    trigger(13'hA2D);
    for (n = 0; n < 20000 && fe !== 1'b1; n++)
    begin
      @(negedge clock);
      if (awake === 1'b1 || acq_start === 1'b1)
        woke = 1'b1;
      if (frame_error === 1'b1)
        fe = 1'b1;
    end
    check("awake with other select", 1'b0, woke);
    check("host frame_error on silence", 1'b1, fe);
  endtask

  // main sequence
  initial
  begin
    err_count = 0;
    checked = 0;
    reset_n = 1'b0;
    ce = 1'b1;
    host_start = 1'b0;
    bit_cycles = 13'hA2D;
    interface_select_setting = SEL_SINGLE_WIRE;
    byte_gap_setting = GAP_SET_DEFAULT;
    acq_done = 1'b0;
    acq_data = 16'h0000;
    do_reset();
    full_reply();
    remeasure();
    short_pulse();
    select_off();
    close_out();
  end
endmodule

// File: bench/swu_link_checker.sv
`timescale 1ns/1ps
// watches the shared line between the two ends; sees only interface signals
module swu_link_checker
  import swu_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic host_out,
  input wire logic host_oe,
  input wire logic shared_serial_line
);
  // longest device low run: start bit plus eight low data bits at the slowest rate
  localparam logic [16:0] RUN_MAX = 17'(9 * PERIOD_MAX_CYC_INT);
  logic [16:0] dev_run_r; // cycles the device has held the line low so far
  logic [16:0] host_run_r; // cycles the host has held the line low so far

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // run counters; a counter keeps the long bit times out of repetition operators
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      dev_run_r <= 17'h0;
      host_run_r <= 17'h0;
    end
    else
    begin
      dev_run_r <= dev_oe ? dev_run_r + 17'h1 : 17'h0;
      host_run_r <= host_oe ? host_run_r + 17'h1 : 17'h0;
    end
  end

  a_reset_quiet:
    assert property (!$past(reset_n) |-> !dev_oe && !host_oe)
    else $error("line driven right after reset");
  a_dev_open_drain:
    assert property (dev_oe |-> !dev_out)
    else $error("device drives the line high");
  a_host_open_drain:
    assert property (host_oe |-> !host_out)
    else $error("host drives the line high");
  a_no_contention:
    assert property (!(dev_oe && host_oe))
    else $error("device and host pull the line together");
  a_bit_min_len:
    assert property ($fell(dev_oe) |-> dev_run_r >= 17'(PERIOD_MIN_CYC))
    else $error("device low run shorter than one bit");
  a_frame_max_run:
    assert property (dev_run_r <= RUN_MAX)
    else $error("device low run longer than start plus eight bits");
  a_stop_released:
    assert property ($fell(dev_oe) |-> !dev_oe [*8])
    else $error("device released the line for too short a time");
  a_host_low_min:
    assert property ($fell(host_oe) |-> host_run_r >= WAKE_MIN_CYC)
    else $error("host low level shorter than the least");
endmodule

// File: rtl/swu_dev.sv
`timescale 1ns/1ps
// Function
// - measured high pulse sets reply bit period
// - host high pulse is one bit period
// - bit period remeasured on every trigger
// - rate kept within 4800 to 9600 baud
// - reply is 16-bit result in two bytes
// - one stop bit, no parity, idle high
// - high byte, programmed gap, then low byte
// - first falling edge wakes idle device
// - host wake low at least 30 us
// - host trailing low at least 30 us
// - acquisition starts only after host release
// - acquire only on trigger, finish before reply
// - release line and idle after low byte
// - active only when interface select chooses it
// - data bits sent least significant first
// - byte gap is (10+4*setting)/1.2 us
// - derived rate within 2 percent of host
module swu_dev
  import swu_pkg::*;
#(
  parameter int PW = 13,
  parameter logic [16:0] LEVEL_MAX_CYC = 17'(swu_pkg::LEVEL_MAX_CYC_INT),
  parameter logic [12:0] PERIOD_MAX_CYC = 13'(swu_pkg::PERIOD_MAX_CYC_INT)
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  swu_link_if.dev link,
  input wire logic [2:0] interface_select_setting,
  input wire logic [7:0] byte_gap_setting,
  output logic acq_start,
  input wire logic acq_done,
  input wire logic [15:0] acq_data,
  output logic awake,
  output logic [PW-1:0] bit_period
);
  import swu_pkg::*;

  // sequence of one trigger and reply
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, // low power, waiting for a falling edge
    ST_WAKE = 4'h1, // timing the wake low level
    ST_BAUD = 4'h2, // timing the rate-setting high pulse
    ST_TAIL = 4'h3, // timing the trailing low level
    ST_ACQ = 4'h4, // acquisition running
    ST_TXH = 4'h5, // high byte on the line
    ST_GAP = 4'h6, // gap between the bytes
    ST_TXL = 4'h7 // low byte on the line
  } swu_dev_state_type;

  // whole state of the device end
  typedef struct packed {
    swu_dev_state_type st;
    logic [16:0] cnt;
    logic [PW-1:0] period;
    logic [15:0] data;
    logic [15:0] gap;
    logic line_q;
    logic acq_start;
    logic tx_start;
    logic [7:0] tx_byte;
  } swu_dev_reg_type;

  swu_dev_reg_type r_r; // registered state
  swu_dev_reg_type r_nxt; // next state

  logic line; // current level of the shared line
  logic line_fall; // falling edge seen this cycle
  logic mode_on; // link selected by the interface setting
  logic tx_busy; // shifter is sending a frame
  logic tx_done; // shifter finished its stop bit
  logic tx_low; // shifter wants the line low
  logic [16:0] cnt_inc; // counter plus one
  logic [16:0] per_min; // least bit period, counter width
  logic [16:0] per_max; // longest bit period, counter width

  // the line is taken as synchronous to the clock
  assign line = link.shared_serial_line;
  assign line_fall = r_r.line_q & ~line;
  assign mode_on = (interface_select_setting == SEL_SINGLE_WIRE);
  assign cnt_inc = r_r.cnt + 17'h1;
  assign per_min = 17'(PERIOD_MIN_CYC);
  assign per_max = 17'(PERIOD_MAX_CYC);

  // byte frame shifter, fed one byte at a time
  swu_tx_byte #(
    .PW(PW)
  ) swu_tx_byte_inst (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .start(r_r.tx_start),
    .byte_in(r_r.tx_byte),
    .period(r_r.period),
    .busy(tx_busy),
    .done(tx_done),
    .drive_low(tx_low)
  );

  // trigger decoding, acquisition handshake and reply sequencing
  always_comb
  begin
    r_nxt = r_r;
    r_nxt.line_q = line;
    r_nxt.acq_start = 1'b0;
    r_nxt.tx_start = 1'b0;
    case (r_r.st)
      ST_IDLE:
      begin
        // nothing runs here until the host pulls the line down
        r_nxt.cnt = 17'h1;
        if (line_fall && mode_on)
        begin
          r_nxt.st = ST_WAKE;
        end
      end
      ST_WAKE:
      begin
        if (line)
        begin
          // a glitch shorter than the wake level is not a trigger
          if (r_r.cnt >= WAKE_MIN_CYC)
          begin
            r_nxt.st = ST_BAUD;
            r_nxt.cnt = 17'h1;
          end
          else
          begin
            r_nxt.st = ST_IDLE;
          end
        end
        else if (r_r.cnt >= LEVEL_MAX_CYC)
        begin
          // line stuck low: give up and wait for the next edge
          r_nxt.st = ST_IDLE;
        end
        else
        begin
          r_nxt.cnt = cnt_inc;
        end
      end
      ST_BAUD:
      begin
        if (!line)
        begin
          // the pulse width in cycles is the bit period from now on
          if (r_r.cnt >= per_min && r_r.cnt <= per_max)
          begin
            r_nxt.period = PW'(r_r.cnt);
            r_nxt.st = ST_TAIL;
            r_nxt.cnt = 17'h1;
          end
          else
          begin
            r_nxt.st = ST_IDLE;
          end
        end
        else if (r_r.cnt > per_max)
        begin
          // too long for any legal rate; abandon the trigger
          r_nxt.st = ST_IDLE;
        end
        else
        begin
          r_nxt.cnt = cnt_inc;
        end
      end
      ST_TAIL:
      begin
        if (line)
        begin
          // the release after a long enough low level starts the work
          if (r_r.cnt >= WAKE_MIN_CYC)
          begin
            r_nxt.st = ST_ACQ;
            r_nxt.acq_start = 1'b1;
          end
          else
          begin
            r_nxt.st = ST_IDLE;
          end
        end
        else if (r_r.cnt >= LEVEL_MAX_CYC)
        begin
          r_nxt.st = ST_IDLE;
        end
        else
        begin
          r_nxt.cnt = cnt_inc;
        end
      end
      ST_ACQ:
      begin
        // no reply bit leaves before the result is complete
        if (acq_done)
        begin
          r_nxt.data = acq_data;
          r_nxt.tx_byte = acq_data[15:8];
          r_nxt.tx_start = 1'b1;
          r_nxt.gap = gap_cycles(byte_gap_setting);
          r_nxt.st = ST_TXH;
        end
      end
      ST_TXH:
      begin
        if (tx_done)
        begin
          r_nxt.st = ST_GAP;
          r_nxt.cnt = 17'h1;
        end
      end
      ST_GAP:
      begin
        // gap is counted from the end of the high byte's stop bit
        if (r_r.cnt >= 17'(r_r.gap))
        begin
          r_nxt.tx_byte = r_r.data[7:0];
          r_nxt.tx_start = 1'b1;
          r_nxt.st = ST_TXL;
        end
        else
        begin
          r_nxt.cnt = cnt_inc;
        end
      end
      ST_TXL:
      begin
        // after the stop bit the shifter has already let go of the line
        if (tx_done)
        begin
          r_nxt.st = ST_IDLE;
        end
      end
      default:
      begin
        r_nxt.st = ST_IDLE;
      end
    endcase
  end

  // state register, frozen while ce is low
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      r_r <= '0;
      r_r.line_q <= 1'b1;
      r_r.tx_byte <= 8'hFF;
    end
    else if (ce)
    begin
      r_r <= r_nxt;
    end
  end

  // open drain: the pin only ever pulls low, and only while a frame runs
  assign link.dev_out = 1'b0;
  assign link.dev_oe = tx_low;
  assign acq_start = r_r.acq_start;
  assign awake = (r_r.st != ST_IDLE);
  assign bit_period = r_r.period;
endmodule

// File: rtl/swu_host.sv
`timescale 1ns/1ps
// host end: sends the trigger, then receives the two reply bytes
module swu_host
  import swu_pkg::*;
#(
  parameter int PW = 13,
  parameter logic [23:0] ACQ_MAX_CYC = 24'(swu_pkg::ACQ_MAX_CYC_INT)
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  swu_link_if.host link,
  input wire logic start,
  input wire logic [PW-1:0] bit_cycles,
  output logic busy,
  output logic [15:0] result,
  output logic result_valid,
  output logic frame_error
);
  import swu_pkg::*;

  // trigger and receive sequence
  typedef enum logic [3:0] {
    HS_IDLE = 4'h0, // waiting for a request
    HS_WAKE = 4'h1, // wake low level
    HS_BAUD = 4'h2, // rate-setting high pulse
    HS_TAIL = 4'h3, // trailing low level
    HS_HUNT = 4'h4, // line released, waiting for a start bit
    HS_STRT = 4'h5, // checking the start bit at mid-bit
    HS_DATA = 4'h6, // sampling data bits
    HS_STOP = 4'h7 // sampling the stop bit
  } swu_host_state_type;

  // whole state of the host end
  typedef struct packed {
    swu_host_state_type st;
    logic [23:0] cnt;
    logic [PW-1:0] period;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [15:0] res;
    logic second;
    logic drive_low;
    logic valid;
    logic err;
  } swu_host_reg_type;

  swu_host_reg_type r_r; // registered state
  swu_host_reg_type r_nxt; // next state
  logic line; // resolved line level
  logic [23:0] per; // bit period at counter width
  logic [23:0] wake; // low level length at counter width

  assign line = link.shared_serial_line;
  assign per = 24'(r_r.period);
  assign wake = 24'(WAKE_MIN_CYC);

  // sequencer; the request is ignored while busy
  always_comb
  begin
    r_nxt = r_r;
    r_nxt.valid = 1'b0;
    r_nxt.err = 1'b0;
    r_nxt.cnt = r_r.cnt + 24'h1;
    case (r_r.st)
      HS_IDLE:
      begin
        r_nxt.cnt = 24'h0;
        if (start)
        begin
          r_nxt.period = bit_cycles;
          r_nxt.drive_low = 1'b1;
          r_nxt.second = 1'b0;
          r_nxt.st = HS_WAKE;
        end
      end
      HS_WAKE:
      begin
        if (r_r.cnt == wake - 24'h1)
        begin
          r_nxt.drive_low = 1'b0;
          r_nxt.cnt = 24'h0;
          r_nxt.st = HS_BAUD;
        end
      end
      HS_BAUD:
      begin
        // high pulse lasts exactly one bit of the expected reply
        if (r_r.cnt == per - 24'h1)
        begin
          r_nxt.drive_low = 1'b1;
          r_nxt.cnt = 24'h0;
          r_nxt.st = HS_TAIL;
        end
      end
      HS_TAIL:
      begin
        if (r_r.cnt == wake - 24'h1)
        begin
          r_nxt.drive_low = 1'b0;
          r_nxt.cnt = 24'h0;
          r_nxt.st = HS_HUNT;
        end
      end
      HS_HUNT:
      begin
        // acquisition may take long; bounded so a dead device is seen
        if (!line)
        begin
          r_nxt.cnt = 24'h0;
          r_nxt.st = HS_STRT;
        end
        else if (r_r.cnt >= ACQ_MAX_CYC)
        begin
          r_nxt.err = 1'b1;
          r_nxt.st = HS_IDLE;
        end
      end
      HS_STRT:
      begin
        if (r_r.cnt == (per >> 1))
        begin
          r_nxt.cnt = 24'h0;
          r_nxt.bitn = 4'h0;
          // a start bit that is gone by mid-bit was noise
          r_nxt.st = line ? HS_HUNT : HS_DATA;
        end
      end
      HS_DATA:
      begin
        if (r_r.cnt == per - 24'h1)
        begin
          r_nxt.cnt = 24'h0;
          r_nxt.sh = {line, r_r.sh[7:1]};
          if (r_r.bitn == DATA_LAST)
          begin
            r_nxt.st = HS_STOP;
          end
          else
          begin
            r_nxt.bitn = r_r.bitn + 4'h1;
          end
        end
      end
      HS_STOP:
      begin
        if (r_r.cnt == per - 24'h1)
        begin
          r_nxt.cnt = 24'h0;
          if (!line)
          begin
            r_nxt.err = 1'b1;
            r_nxt.st = HS_IDLE;
          end
          else if (!r_r.second)
          begin
            r_nxt.res[15:8] = r_r.sh;
            r_nxt.second = 1'b1;
            r_nxt.st = HS_HUNT;
          end
          else
          begin
            r_nxt.res[7:0] = r_r.sh;
            r_nxt.valid = 1'b1;
            r_nxt.st = HS_IDLE;
          end
        end
      end
      default:
      begin
        r_nxt.st = HS_IDLE;
      end
    endcase
  end

  // state register, frozen while ce is low
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      r_r <= '0;
    end
    else if (ce)
    begin
      r_r <= r_nxt;
    end
  end

  // open drain output: pull low or release to the pull-up
  assign link.host_out = 1'b0;
  assign link.host_oe = r_r.drive_low;
  assign busy = (r_r.st != HS_IDLE);
  assign result = r_r.res;
  assign result_valid = r_r.valid;
  assign frame_error = r_r.err;
endmodule

// File: rtl/swu_link_if.sv
`timescale 1ns/1ps
// the shared serial line: open drain with a pull-up, resolved here
interface swu_link_if;
  logic dev_out; // device pin output value
  logic dev_oe; // device drives the pin while high
  logic host_out; // host pin output value
  logic host_oe; // host drives the pin while high
  logic shared_serial_line; // resolved level seen by both ends

  // pull-up wins unless some driver pulls low
  assign shared_serial_line = ~((dev_oe & ~dev_out) | (host_oe & ~host_out));

  modport dev (input shared_serial_line, output dev_out, output dev_oe);
  modport host (input shared_serial_line, output host_out, output host_oe);
endinterface

// File: rtl/swu_pkg.sv
// shared constants for the single-wire trigger/response serial link
package swu_pkg;

  // system clock rate
  localparam int CLK_HZ = 25_000_000;
  localparam int US_PER_S = 1_000_000;

  // least low time of the wake level and of the trailing low level
  localparam int WAKE_MIN_US = 30;
  localparam logic [16:0] WAKE_MIN_CYC = 17'((WAKE_MIN_US * CLK_HZ + US_PER_S - 1) / US_PER_S);

  // longest low level before a trigger is given up (5000 us)
  localparam int LEVEL_MAX_US = 5000;
  localparam int LEVEL_MAX_CYC_INT = (LEVEL_MAX_US / 1000) * (CLK_HZ / 1000);

  // accepted reply rate range in bits per second
  localparam int BAUD_MIN = 4_800;
  localparam int BAUD_MAX = 9_600;
  // shortest bit period rounds up, longest rounds down
  localparam logic [12:0] PERIOD_MIN_CYC = 13'((CLK_HZ + BAUD_MAX - 1) / BAUD_MAX);
  localparam int PERIOD_MAX_CYC_INT = CLK_HZ / BAUD_MIN;

  // bits of one byte frame: start, eight data, stop
  localparam logic [3:0] FRAME_BITS = 4'hA;
  localparam logic [3:0] DATA_LAST = 4'h7;

  // longest wait for the reply after the trigger (400 ms)
  localparam int ACQ_MAX_MS = 400;
  localparam int ACQ_MAX_CYC_INT = ACQ_MAX_MS * (CLK_HZ / 1000);

  // interface-select setting codes; only the first selects this link
  localparam logic [2:0] SEL_SINGLE_WIRE = 3'h0;
  localparam logic [2:0] SEL_DEFAULT = 3'h3;

  // byte gap setting default and the gap formula (10 + 4 * setting) / 1.2 us
  localparam logic [7:0] GAP_SET_DEFAULT = 8'h94;
  localparam int GAP_BASE_US10 = 10;
  localparam int GAP_STEP = 4;
  localparam int GAP_DIV = 12;

  // gap between the two reply bytes in clock cycles
  function automatic logic [15:0] gap_cycles(input logic [7:0] setting);
    int tenths;
    tenths = (GAP_BASE_US10 + GAP_STEP * int'(setting)) * 10;
    gap_cycles = 16'((tenths * (CLK_HZ / US_PER_S)) / GAP_DIV);
  endfunction

endpackage

// File: rtl/swu_tx_byte.sv
`timescale 1ns/1ps
// one byte frame shifter: start bit, eight data bits lsb first, stop bit
module swu_tx_byte
  import swu_pkg::*;
#(
  parameter int PW = 13
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic start,
  input wire logic [7:0] byte_in,
  input wire logic [PW-1:0] period,
  output logic busy,
  output logic done,
  output logic drive_low
);
  import swu_pkg::*;

  // whole state of the shifter
  typedef struct packed {
    logic busy;
    logic done;
    logic drive_low;
    logic [PW-1:0] cnt;
    logic [3:0] idx;
    logic [9:0] sh;
  } swu_tx_reg_type;

  swu_tx_reg_type r_r; // registered state
  swu_tx_reg_type r_nxt; // next state

  // frame timing: each bit stands exactly one measured period
  always_comb
  begin
    r_nxt = r_r;
    r_nxt.done = 1'b0;
    if (!r_r.busy)
    begin
      if (start)
      begin
        // stop bit high at top, start bit low at bottom
        r_nxt.busy = 1'b1;
        r_nxt.sh = {1'b1, byte_in, 1'b0};
        r_nxt.cnt = {{(PW-1){1'b0}}, 1'b1};
        r_nxt.idx = 4'h0;
      end
    end
    else if (r_r.cnt >= period)
    begin
      // bit boundary
      r_nxt.cnt = {{(PW-1){1'b0}}, 1'b1};
      r_nxt.sh = {1'b1, r_r.sh[9:1]};
      if (r_r.idx == FRAME_BITS - 4'h1)
      begin
        r_nxt.busy = 1'b0;
        r_nxt.done = 1'b1;
      end
      else
      begin
        r_nxt.idx = r_r.idx + 4'h1;
      end
    end
    else
    begin
      r_nxt.cnt = r_r.cnt + {{(PW-1){1'b0}}, 1'b1};
    end
    // only low bits are driven; high bits are left to the pull-up
    r_nxt.drive_low = r_nxt.busy & ~r_nxt.sh[0];
  end

  // state register, frozen while ce is low
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      r_r <= '0;
    end
    else if (ce)
    begin
      r_r <= r_nxt;
    end
  end

  assign busy = r_r.busy;
  assign done = r_r.done;
  assign drive_low = r_r.drive_low;
endmodule
